// ===== rtl/otp_port_pkg.sv
// constants, types and carrier structs of the otp programming port
// assumes a single 20 MHz system clock and an active-low async reset
package otp_port_pkg;

  localparam int CLK_PERIOD_NS = 50;
  localparam int ADDR_W = 11;
  localparam int DATA_W = 8;

  localparam int DATA_ACCESS_NS = 188;
  localparam int DATA_FLOAT_NS = 100;
  localparam int DATA_ACCESS_CYC = DATA_ACCESS_NS / CLK_PERIOD_NS;
  localparam int DATA_FLOAT_CYC = DATA_FLOAT_NS / CLK_PERIOD_NS;

  localparam logic [DATA_W-1:0] ERASED_BYTE = 8'hFF;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 11'h000;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 11'h001;

  // fuse bit positions
  localparam int OPT_NUM = 5;
  localparam int OPT_ROM_PROTECT = 0;
  localparam int OPT_LATCH_OFF = 1;
  localparam int OPT_WDT_PERM = 2;
  localparam int OPT_TEST_OFF = 3;
  localparam int OPT_LOW_NOISE = 4;
  localparam logic [OPT_NUM-1:0] FUSES_BLANK = 5'h00;

  typedef enum logic [2:0] {
    OP_IDLE,
    OP_READ,
    OP_PROGRAM,
    OP_VERIFY,
    OP_OPTION
  } op_t;

  // programming pins after remap, digital view
  typedef struct packed {
    logic ce_n;
    logic ce_hv;
    logic read_en_n;
    logic prog_mode_select;
    logic mode_hv;
    logic supply_hv;
    logic program_strobe_n;
    logic addr_clear;
    logic addr_step;
  } pins_t;

  localparam pins_t PINS_IDLE = '{
    ce_n: 1'b1, ce_hv: 1'b0, read_en_n: 1'b1, prog_mode_select: 1'b0, mode_hv: 1'b0,
    supply_hv: 1'b0, program_strobe_n: 1'b1, addr_clear: 1'b0, addr_step: 1'b0};

endpackage

// ===== rtl/pin_sync3.sv
// three-stage pin synchroniser with agreement filter
// assumes the inputs are asynchronous to CLK_SYS
`timescale 1ns/1ps
module pin_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // pins in, filtered level out
  input wire logic [W-1:0] PIN,
  output logic [W-1:0] LEVEL
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] level_r;
  logic [W-1:0] level_nxt;

  // a bit only moves when stages two and three agree
  assign level_nxt = (s2_r & ~(s2_r ^ s3_r)) | (level_r & (s2_r ^ s3_r));

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
      level_r <= RST_VAL;
    end else begin
      s1_r <= PIN;
      s2_r <= s1_r;
      s3_r <= s2_r;
      level_r <= level_nxt;
    end
  end

  assign LEVEL = level_r;

endmodule

// ===== rtl/otp_prog_port.sv
// otp code memory with its pin-driven programming port and fuse options
// assumes programmer pins are asynchronous; high-voltage levels arrive as detector bits
`timescale 1ns/1ps
module otp_prog_port #(
  parameter int ADDR_W = otp_port_pkg::ADDR_W,
  parameter int DATA_W = otp_port_pkg::DATA_W
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic RST_N,
  // remapped programming pins
  input wire logic CRYSTAL_IN_PIN,
  input wire logic CE_HV_DET,
  input wire logic READ_ENABLE_PIN,
  input wire logic MODE_PIN,
  input wire logic MODE_HV_DET,
  input wire logic SUPPLY_PIN,
  input wire logic STROBE_PIN,
  input wire logic ADDR_CLEAR_PIN,
  input wire logic ADDR_STEP_PIN,
  // data pins
  input wire logic [DATA_W-1:0] DATA_IN,
  output logic [DATA_W-1:0] DATA_OUT,
  output logic DATA_OE,
  // internal code fetch
  input wire logic [ADDR_W-1:0] CODE_ADDR,
  output logic [DATA_W-1:0] CODE_DATA,
  // core state
  input wire logic WDT_SW_EN,
  input wire logic HALT_MODE,
  input wire logic STOP_MODE,
  // option effects and status
  output logic PIN_REMAP,
  output logic PROG_BLOCKED,
  output logic AUTO_LATCH_EN,
  output logic WDT_RUN,
  output logic LOW_NOISE,
  output logic SYS_CLK_EN,
  output logic [ADDR_W-1:0] ADDR_COUNT
);

  localparam int PW = $bits(otp_port_pkg::pins_t);
  localparam int DEPTH = 1 << ADDR_W;
  localparam int ACC_CYC = otp_port_pkg::DATA_ACCESS_CYC;
  localparam int FLT_CYC = otp_port_pkg::DATA_FLOAT_CYC;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisation
  otp_port_pkg::pins_t pins_raw;
  otp_port_pkg::pins_t pins_s;
  otp_port_pkg::pins_t pins_d_r;
  logic [DATA_W-1:0] data_s;

  // crystal input doubles as chip enable in this mode
  assign pins_raw = '{
    ce_n: CRYSTAL_IN_PIN, ce_hv: CE_HV_DET, read_en_n: READ_ENABLE_PIN,
    prog_mode_select: MODE_PIN, mode_hv: MODE_HV_DET, supply_hv: SUPPLY_PIN,
    program_strobe_n: STROBE_PIN, addr_clear: ADDR_CLEAR_PIN, addr_step: ADDR_STEP_PIN};

  pin_sync3 #(
    .W(PW),
    .RST_VAL(otp_port_pkg::PINS_IDLE)
  ) u_pin_sync (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .PIN(pins_raw),
    .LEVEL(pins_s)
  );

  pin_sync3 #(
    .W(DATA_W),
    .RST_VAL('0)
  ) u_data_sync (
    .CLK_SYS(CLK_SYS),
    .RST_N(RST_N),
    .PIN(DATA_IN),
    .LEVEL(data_s)
  );

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      pins_d_r <= otp_port_pkg::PINS_IDLE;
    end else begin
      pins_d_r <= pins_s;
    end
  end

  wire step_rise = pins_s.addr_step & ~pins_d_r.addr_step;
  wire strobe_fall = ~pins_s.program_strobe_n & pins_d_r.program_strobe_n;

  //////////////////////////////////////////////////////////////////////
  // fuses and the test-disable latch
  logic [otp_port_pkg::OPT_NUM-1:0] fuse_r = otp_port_pkg::FUSES_BLANK;
  logic [otp_port_pkg::OPT_NUM-1:0] burn_sel;
  logic started_r;
  logic blocked_r;

  // the disable only bites after a power cycle, the reset stands in for it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      started_r <= 1'b0;
      blocked_r <= 1'b1;
    end else if (!started_r) begin
      started_r <= 1'b1;
      blocked_r <= fuse_r[otp_port_pkg::OPT_TEST_OFF];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // mode and operation decode
  otp_port_pkg::op_t op;
  wire prog_mode = ~blocked_r & (pins_s.mode_hv | pins_s.supply_hv);
  wire chip_sel = prog_mode & ~pins_s.ce_n & ~pins_s.ce_hv;
  wire rd_sel = chip_sel & ~pins_s.read_en_n & pins_s.program_strobe_n;

  always_comb begin
    op = otp_port_pkg::OP_IDLE;
    if (prog_mode && pins_s.ce_hv && pins_s.supply_hv && !pins_s.program_strobe_n) begin
      op = otp_port_pkg::OP_OPTION;
    end else if (rd_sel && !pins_s.supply_hv) begin
      op = otp_port_pkg::OP_READ;
    end else if (rd_sel) begin
      op = otp_port_pkg::OP_VERIFY;
    end else if (chip_sel && pins_s.supply_hv && pins_s.read_en_n && !pins_s.program_strobe_n) begin
      op = otp_port_pkg::OP_PROGRAM;
    end
  end

  // option row picked by mode level and mode pin, fuse in the row by read enable
  wire [1:0] row_sel = {pins_s.mode_hv, pins_s.prog_mode_select};
  always_comb begin
    burn_sel = otp_port_pkg::FUSES_BLANK;
    case (row_sel)
      2'h3, 2'h2: burn_sel[otp_port_pkg::OPT_ROM_PROTECT] = pins_s.read_en_n;
      2'h1: begin
        burn_sel[otp_port_pkg::OPT_LATCH_OFF] = pins_s.read_en_n;
        burn_sel[otp_port_pkg::OPT_WDT_PERM] = ~pins_s.read_en_n;
      end
      2'h0: begin
        burn_sel[otp_port_pkg::OPT_TEST_OFF] = pins_s.read_en_n;
        burn_sel[otp_port_pkg::OPT_LOW_NOISE] = ~pins_s.read_en_n;
      end
      default: burn_sel = otp_port_pkg::FUSES_BLANK;
    endcase
  end

  wire burn_go = strobe_fall & (op == otp_port_pkg::OP_OPTION);

  // each fuse burns only on its own strobe
  for (genvar i = 0; i < otp_port_pkg::OPT_NUM; i++) begin : g_fuse
    always_ff @(posedge CLK_SYS) begin
      if (burn_go && burn_sel[i]) begin
        fuse_r[i] <= 1'b1;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // address counter
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;

  assign addr_nxt = pins_s.addr_clear ? ADDR_W'(otp_port_pkg::ADDR_ZERO)
                  : step_rise ? addr_r + ADDR_W'(otp_port_pkg::ADDR_ONE)
                  : addr_r;

  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      addr_r <= ADDR_W'(otp_port_pkg::ADDR_ZERO);
    end else if (prog_mode) begin
      addr_r <= addr_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // code array
  // array starts erased and is never reset
  logic [DATA_W-1:0] mem [DEPTH] = '{default: otp_port_pkg::ERASED_BYTE};
  logic [DATA_W-1:0] rd_data_r;
  logic [DATA_W-1:0] code_data_r;

  // cells only go from one to zero
  always_ff @(posedge CLK_SYS) begin
    if (strobe_fall && op == otp_port_pkg::OP_PROGRAM) begin
      mem[addr_r] <= mem[addr_r] & data_s;
    end
  end

  // byte at the counter is fetched ahead of the read enable
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      rd_data_r <= '0;
      code_data_r <= '0;
    end else begin
      rd_data_r <= mem[addr_r];
      code_data_r <= mem[CODE_ADDR];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // data pins, enable straight from pins to meet access and float times
  wire ext_rd_ok = ~blocked_r & ~fuse_r[otp_port_pkg::OPT_ROM_PROTECT];
  wire pin_rd = ~CRYSTAL_IN_PIN & ~CE_HV_DET & ~READ_ENABLE_PIN & STROBE_PIN;

  assign DATA_OE = ext_rd_ok & prog_mode & pin_rd;
  assign DATA_OUT = rd_data_r;
  assign CODE_DATA = code_data_r;
  assign ADDR_COUNT = addr_r;
  assign PIN_REMAP = prog_mode;
  assign PROG_BLOCKED = blocked_r;

  //////////////////////////////////////////////////////////////////////
  // option effects on the core
  logic div_r;

  assign AUTO_LATCH_EN = ~fuse_r[otp_port_pkg::OPT_LATCH_OFF];
  assign WDT_RUN = started_r & (fuse_r[otp_port_pkg::OPT_WDT_PERM]
                 | (WDT_SW_EN & ~HALT_MODE & ~STOP_MODE));
  assign LOW_NOISE = fuse_r[otp_port_pkg::OPT_LOW_NOISE];

  // divide by two unless low noise bypasses it
  always_ff @(posedge CLK_SYS or negedge RST_N) begin
    if (!RST_N) begin
      div_r <= 1'b0;
    end else begin
      div_r <= ~div_r;
    end
  end

  assign SYS_CLK_EN = LOW_NOISE | div_r;

  //////////////////////////////////////////////////////////////////////
  // checks
  step_once_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    prog_mode && step_rise && !pins_s.addr_clear |=> addr_r == $past(addr_r) + ADDR_W'(1))
    else $error("address did not step by one");

  clear_zero_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    prog_mode && pins_s.addr_clear |=> addr_r == '0)
    else $error("address not cleared");

  read_data_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(DATA_OE) && $stable(addr_r) |-> ##[0:ACC_CYC] DATA_OUT == mem[addr_r])
    else $error("read data late");

  float_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    READ_ENABLE_PIN || CRYSTAL_IN_PIN |-> ##[0:FLT_CYC] !DATA_OE)
    else $error("data pins not released");

  protect_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    fuse_r[otp_port_pkg::OPT_ROM_PROTECT] |-> !DATA_OE)
    else $error("protected code driven out");

  blocked_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    blocked_r |-> !PIN_REMAP && !DATA_OE && op == otp_port_pkg::OP_IDLE)
    else $error("blocked device entered programming");

  remap_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    PIN_REMAP == (!blocked_r && (pins_s.mode_hv || pins_s.supply_hv)))
    else $error("pin remap wrong");

  latch_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(fuse_r[otp_port_pkg::OPT_LATCH_OFF]) |-> !AUTO_LATCH_EN)
    else $error("keepers still on");

  wdt_perm_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    started_r && fuse_r[otp_port_pkg::OPT_WDT_PERM] |-> WDT_RUN)
    else $error("watchdog stopped");

  noise_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    $rose(fuse_r[otp_port_pkg::OPT_ROM_PROTECT]) && !$past(LOW_NOISE) |-> !LOW_NOISE)
    else $error("protect switched on low noise");

  clk_div_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !LOW_NOISE && SYS_CLK_EN |=> !SYS_CLK_EN || LOW_NOISE)
    else $error("divide by two missing");

  fuse_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    !burn_go |=> fuse_r == $past(fuse_r))
    else $error("fuse changed without its strobe");

  block_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    blocked_r |=> ADDR_COUNT == $past(ADDR_COUNT))
    else $error("blocked device moved its counter");

  clk_full_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    LOW_NOISE |-> SYS_CLK_EN)
    else $error("low noise clock still divided");

  fetch_data_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    started_r && !(strobe_fall && op == otp_port_pkg::OP_PROGRAM) |=> CODE_DATA == mem[$past(CODE_ADDR)])
    else $error("internal fetch data wrong");

  oe_gate_a: assert property (@(posedge CLK_SYS) disable iff (!RST_N)
    DATA_OE |-> !CRYSTAL_IN_PIN && !READ_ENABLE_PIN && STROBE_PIN)
    else $error("data driven without both enables");

  prog_c: cover property (@(posedge CLK_SYS) disable iff (!RST_N)
    strobe_fall && op == otp_port_pkg::OP_PROGRAM);
  read_c: cover property (@(posedge CLK_SYS) disable iff (!RST_N) $rose(DATA_OE));
  burn_c: cover property (@(posedge CLK_SYS) disable iff (!RST_N) burn_go);
  step_c: cover property (@(posedge CLK_SYS) disable iff (!RST_N) prog_mode && step_rise);
  verify_c: cover property (@(posedge CLK_SYS) disable iff (!RST_N) op == otp_port_pkg::OP_VERIFY && DATA_OE);

endmodule

// ===== test/otp_programmer.sv
// programmer model: drives the remapped pins and the data pins
// assumes tasks are entered right after a rising edge of clk
`timescale 1ns/1ps
module otp_programmer #(
  parameter int SETUP_CYC = 40,
  parameter int PROG_CYC = 19000,
  parameter int OVER_CYC = 57000,
  parameter int OPT_CYC = 1560000
) (
  // clock
  input wire logic clk,
  // pins to the device
  output otp_port_pkg::pins_t pins,
  output logic [7:0] data_in,
  // data pins from the device
  input wire logic [7:0] data_out,
  input wire logic data_oe
);
  initial begin
    pins = otp_port_pkg::PINS_IDLE;
    data_in = 8'h00;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic set_mode(input logic hv, input logic mp, input logic sup);
    pins.mode_hv <= hv;
    pins.prog_mode_select <= mp;
    pins.supply_hv <= sup;
    pins.ce_n <= 1'b0;
    tick(SETUP_CYC);
  endtask

  task automatic step();
    pins.addr_step <= 1'b1;
    tick(8);
    pins.addr_step <= 1'b0;
    tick(SETUP_CYC);
  endtask

  // a step while clear is held must not count
  task automatic clear();
    pins.addr_clear <= 1'b1;
    tick(8);
    step();
    pins.addr_clear <= 1'b0;
    tick(SETUP_CYC);
  endtask

  task automatic read(output logic [7:0] d, output logic on, output logic off);
    pins.read_en_n <= 1'b0;
    tick(5);
    d = data_out;
    on = data_oe;
    pins.read_en_n <= 1'b1;
    tick(2);
    off = data_oe;
  endtask

  task automatic pulse(input int n);
    pins.program_strobe_n <= 1'b0;
    tick(n);
    pins.program_strobe_n <= 1'b1;
    tick(SETUP_CYC);
  endtask

  task automatic prog_byte(input logic [7:0] v, output logic [7:0] got);
    logic on, off;
    data_in <= v;
    tick(SETUP_CYC);
    for (int i = 0; i < 3; i++) begin
      pulse(PROG_CYC);
      read(got, on, off);
      if (got === v) break;
    end
    pulse(OVER_CYC);
    data_in <= ~v;
  endtask

  task automatic burn(input logic hv, input logic mp, input logic oe_n);
    pins.ce_hv <= 1'b1;
    pins.supply_hv <= 1'b1;
    pins.mode_hv <= hv;
    pins.prog_mode_select <= mp;
    pins.read_en_n <= oe_n;
    tick(SETUP_CYC);
    pulse(OPT_CYC);
    pins.ce_hv <= 1'b0;
    pins.read_en_n <= 1'b1;
    tick(SETUP_CYC);
  endtask
endmodule

// ===== test/test_otp_prog_port.sv
// self-checking bench for the otp programming port
// assumes fuses start blank and the array erased
`timescale 1ns/1ps
module test_otp_prog_port;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [10:0] code_addr = 11'h000;
  logic wdt_sw_en = 1'b1;
  logic halt_mode = 1'b1;
  logic stop_mode = 1'b0;
  otp_port_pkg::pins_t pins;
  logic [7:0] din, dout, code_data, d;
  logic oe, alatch, wdt_run, low_noise, clk_en, remap, blocked, on, off, s0;
  logic [10:0] acount;
  int failures = 0;
  int n_compared = 0;

  always #25 clk_sys = ~clk_sys;

  otp_prog_port otp_prog_port_inst (
    .CLK_SYS(clk_sys), .RST_N(rst_n), .CRYSTAL_IN_PIN(pins.ce_n), .CE_HV_DET(pins.ce_hv),
    .READ_ENABLE_PIN(pins.read_en_n), .MODE_PIN(pins.prog_mode_select), .MODE_HV_DET(pins.mode_hv),
    .SUPPLY_PIN(pins.supply_hv), .STROBE_PIN(pins.program_strobe_n), .ADDR_CLEAR_PIN(pins.addr_clear),
    .ADDR_STEP_PIN(pins.addr_step), .DATA_IN(din), .DATA_OUT(dout), .DATA_OE(oe),
    .CODE_ADDR(code_addr), .CODE_DATA(code_data), .WDT_SW_EN(wdt_sw_en), .HALT_MODE(halt_mode),
    .STOP_MODE(stop_mode), .PIN_REMAP(remap), .PROG_BLOCKED(blocked), .AUTO_LATCH_EN(alatch),
    .WDT_RUN(wdt_run), .LOW_NOISE(low_noise), .SYS_CLK_EN(clk_en), .ADDR_COUNT(acount));

  otp_programmer #(.PROG_CYC(40), .OVER_CYC(120), .OPT_CYC(200)) otp_programmer_inst (
    .clk(clk_sys), .pins(pins), .data_in(din), .data_out(dout), .data_oe(oe));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic chk_addr(input string what, input logic [10:0] exp, input logic [10:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic reset_dut();
    rst_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (100000) @(posedge clk_sys);
    failures++;
    give_verdict();
  end

  initial begin
    reset_dut();
    @(negedge clk_sys);
    chk_bit("blocked", 1'b0, blocked);
    chk_bit("latch", 1'b1, alatch);
    chk_bit("remap", 1'b0, remap);
    s0 = clk_en;
    @(negedge clk_sys);
    chk_bit("clk_en", ~s0, clk_en);
    @(posedge clk_sys);
    $display("reset test done");
    // read mode, clear overriding a step, back-to-back steps
    otp_programmer_inst.set_mode(1'b1, 1'b0, 1'b0);
    otp_programmer_inst.clear();
    chk_bit("remap", 1'b1, remap);
    chk_addr("count", 11'h000, acount);
    otp_programmer_inst.read(d, on, off);
    chk_byte("blank", otp_port_pkg::ERASED_BYTE, d);
    chk_bit("oe on", 1'b1, on);
    chk_bit("oe off", 1'b0, off);
    for (int i = 1; i <= 3; i++) begin
      otp_programmer_inst.step();
      chk_addr("count", 11'(i), acount);
    end
    otp_programmer_inst.clear();
    otp_programmer_inst.step();
    chk_addr("count", 11'h001, acount);
    $display("read test done");
    // program, verify, second write only clears bits
    otp_programmer_inst.set_mode(1'b0, 1'b1, 1'b1);
    otp_programmer_inst.prog_byte(8'h5A, d);
    chk_byte("verify", 8'h5A, d);
    otp_programmer_inst.prog_byte(8'hF0, d);
    chk_byte("verify", 8'h50, d);
    code_addr <= 11'h001;
    repeat (2) @(posedge clk_sys);
    chk_byte("fetch", 8'h50, code_data);
    $display("program test done");
    // option fuses
    otp_programmer_inst.burn(1'b1, 1'b0, 1'b1);
    chk_bit("low noise", 1'b0, low_noise);
    otp_programmer_inst.set_mode(1'b1, 1'b0, 1'b0);
    otp_programmer_inst.read(d, on, off);
    chk_bit("oe on", 1'b0, on);
    chk_byte("fetch", 8'h50, code_data);
    otp_programmer_inst.burn(1'b0, 1'b1, 1'b1);
    chk_bit("latch", 1'b0, alatch);
    chk_bit("wdt", 1'b0, wdt_run);
    otp_programmer_inst.burn(1'b0, 1'b1, 1'b0);
    chk_bit("wdt", 1'b1, wdt_run);
    stop_mode <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk_bit("wdt", 1'b1, wdt_run);
    otp_programmer_inst.burn(1'b0, 1'b0, 1'b0);
    chk_bit("low noise", 1'b1, low_noise);
    @(negedge clk_sys);
    chk_bit("clk_en", 1'b1, clk_en);
    @(negedge clk_sys);
    chk_bit("clk_en", 1'b1, clk_en);
    @(posedge clk_sys);
    $display("option test done");
    // test disable needs a power cycle
    otp_programmer_inst.burn(1'b0, 1'b0, 1'b1);
    chk_bit("blocked", 1'b0, blocked);
    reset_dut();
    otp_programmer_inst.set_mode(1'b1, 1'b0, 1'b0);
    chk_bit("blocked", 1'b1, blocked);
    chk_bit("remap", 1'b0, remap);
    otp_programmer_inst.step();
    chk_addr("count", 11'h000, acount);
    $display("disable test done");
    give_verdict();
  end
endmodule
